//--- logic/uef_cfg.svh
// offsets, field positions, reset values and timing counts of the usb event flag block
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH

// register byte offsets
`define UEF_OFS_FLAGS 8'h00
`define UEF_OFS_CLEAR 8'h04
`define UEF_OFS_INTEN 8'h08
`define UEF_OFS_ERRF 8'h0c
`define UEF_OFS_ERREN 8'h10
`define UEF_OFS_XSTAT 8'h14
`define UEF_OFS_CTRL 8'h18

// event flag positions
`define UEF_BIT_STALL 7
`define UEF_BIT_ATTACH 6
`define UEF_BIT_RESUME 5
`define UEF_BIT_IDLE 4
`define UEF_BIT_TOKEN 3
`define UEF_BIT_SOF 2
`define UEF_BIT_ERR 1
`define UEF_BIT_RST 0
`define UEF_BIT_HOST_ROLE_ENABLE 0

// hardware-settable flags, summary position excluded
`define UEF_HS_MASK 8'hfd
`define UEF_FLAGS_RESET 8'h00
`define UEF_REG_RESET 8'h00

// timing
`define UEF_CLK_PERIOD_NS 25
`define UEF_K_TIME_NS 2500
`define UEF_K_CYCLES ((`UEF_K_TIME_NS + `UEF_CLK_PERIOD_NS - 1) / `UEF_CLK_PERIOD_NS)
`define UEF_K_W 7
`define UEF_IDLE_TIME_MS 3
`define UEF_IDLE_CYCLES ((`UEF_IDLE_TIME_MS * 1000000 + `UEF_CLK_PERIOD_NS - 1) / `UEF_CLK_PERIOD_NS)
`define UEF_IDLE_W 17

// transfer status queue
`define UEF_XSTAT_W 8
`define UEF_XSTAT_DEPTH 4

`endif

//--- logic/uef_pkg.sv
// types of the usb event flag block
package uef_pkg;
    typedef logic [7:0] uef_flags_t;
    typedef enum {UEF_REG_NONE, UEF_REG_FLAGS, UEF_REG_CLEAR, UEF_REG_INTEN, UEF_REG_ERRF, UEF_REG_ERREN,
        UEF_REG_XSTAT, UEF_REG_CTRL} uef_reg_t;
endpackage : uef_pkg

//--- logic/uef_stat_fifo.sv
// shift-register queue of completed-token status entries
`timescale 1ns/100ps
module uef_stat_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic full,
    // drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic pop_ok;
    logic push_ok;
    logic [CW-1:0] wr_idx;

    assign full = (count == CW'(DEPTH));
    assign pop_ok = pop && (count != '0);
    // a push into a full queue is accepted only when a pop frees the slot
    assign push_ok = push && (!full || pop_ok);
    assign wr_idx = pop_ok ? CW'(count - 1'b1) : count;
    assign head = mem[0];

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (reset)
            count <= '0;
        else if (push_ok && !pop_ok)
            count <= CW'(count + 1'b1);
        else if (pop_ok && !push_ok)
            count <= CW'(count - 1'b1);
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        logic [WIDTH-1:0] shift_in;

        // last slot takes zero on a pop; no entry beyond the end to read
        if (i == DEPTH - 1)
        begin : g_last
            assign shift_in = '0;
        end
        else
        begin : g_mid
            assign shift_in = mem[i + 1];
        end

        always_ff @(posedge clk)
        begin
            if (reset)
                mem[i] <= '0;
            else if (push_ok && wr_idx == CW'(i))
                mem[i] <= push_data;
            else if (pop_ok)
                mem[i] <= shift_in;
        end
    end
endmodule : uef_stat_fifo

//--- logic/uef_top.sv
// usb event flag register block with ahb-lite slave and interrupt output
//
// What this block does
// - bits 31 to 8 of the event flag register read as zero and ignore writes.
// - every flag except the error summary is set by hardware, cleared by writing one, zero after reset.
// - the error summary at bit 1 is read-only and is set only by an error whose enable bit is set.
// - bit 7 sets on a received stall handshake in host role and on a sent one in device role.
// - bit 6 sets on attach only with host role enabled, 2.5 us of bus quiet and the bus not in se0.
// - bit 5 sets once a k-state has lasted 2.5 us on the data lines.
// - bit 4 sets once the bus has stayed idle for 3 ms or longer.
// - bit 3 sets when a token completes; the transfer status register shows the oldest queued entry.
// - clearing bit 3 advances the transfer status queue to the next entry.
// - bit 2 sets on a received sof in device role and on the sof threshold in host role.
// - in device role bit 0 sets when a valid bus reset is seen.
// - in host role bit 0 sets when a detach is seen.
// - an enabled error reaches the interrupt only while interrupt enable bit 1 is set.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "uef_cfg.svh"
module uef_top
#(
    parameter int IDLE_CYCLES = `UEF_IDLE_CYCLES
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // serial engine events
    input wire logic STALL_RX,
    input wire logic STALL_TX,
    input wire logic ATTACH_SEEN,
    input wire logic DETACH_SEEN,
    input wire logic USB_RESET_SEEN,
    input wire logic SOF_RECEIVED,
    input wire logic SOF_THRESHOLD,
    input wire logic TOKEN_DONE,
    input wire logic [7:0] TOKEN_STATUS,
    output logic TOKEN_READY,
    input wire logic [7:0] ERROR_EVENTS,
    // bus line state
    input wire logic BUS_K_STATE,
    input wire logic BUS_IDLE,
    input wire logic BUS_ACTIVE,
    input wire logic BUS_SE0,
    // role and interrupt
    output logic HOST_ROLE_ENABLE,
    output logic IRQ
);
    uef_pkg::uef_reg_t addr_sel;
    uef_pkg::uef_reg_t wr_sel;
    logic addr_phase;
    logic wr_pend;
    uef_pkg::uef_flags_t hs_flags;
    uef_pkg::uef_flags_t flag_set;
    uef_pkg::uef_flags_t flag_clr;
    uef_pkg::uef_flags_t next_hs_flags;
    uef_pkg::uef_flags_t event_flags;
    uef_pkg::uef_flags_t err_flags;
    uef_pkg::uef_flags_t err_enable;
    uef_pkg::uef_flags_t int_enable;
    uef_pkg::uef_flags_t rd_value;
    logic error_summary_flag;
    logic host_en;
    logic [`UEF_K_W-1:0] k_cnt;
    logic [`UEF_K_W-1:0] q_cnt;
    logic [`UEF_IDLE_W-1:0] idle_cnt;
    logic resume_hit;
    logic idle_hit;
    logic quiet_ok;
    logic token_push;
    logic token_pop;
    logic fifo_full;
    logic [`UEF_XSTAT_W-1:0] xstat_head;
    logic [$clog2(`UEF_XSTAT_DEPTH+1)-1:0] fifo_count;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, always okay
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign addr_phase = HSEL && HTRANS[1] && HREADY;

    always_comb
    begin
        addr_sel = uef_pkg::UEF_REG_NONE;
        if (HADDR[31:8] == 24'h000000)
        begin
            case (HADDR[7:0])
                `UEF_OFS_FLAGS: addr_sel = uef_pkg::UEF_REG_FLAGS;
                `UEF_OFS_CLEAR: addr_sel = uef_pkg::UEF_REG_CLEAR;
                `UEF_OFS_INTEN: addr_sel = uef_pkg::UEF_REG_INTEN;
                `UEF_OFS_ERRF: addr_sel = uef_pkg::UEF_REG_ERRF;
                `UEF_OFS_ERREN: addr_sel = uef_pkg::UEF_REG_ERREN;
                `UEF_OFS_XSTAT: addr_sel = uef_pkg::UEF_REG_XSTAT;
                `UEF_OFS_CTRL: addr_sel = uef_pkg::UEF_REG_CTRL;
                default: addr_sel = uef_pkg::UEF_REG_NONE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            wr_pend <= 1'b0;
            wr_sel <= uef_pkg::UEF_REG_NONE;
        end
        else
        begin
            wr_pend <= addr_phase && HWRITE;
            wr_sel <= addr_sel;
        end
    end

    always_comb
    begin
        case (addr_sel)
            uef_pkg::UEF_REG_FLAGS: rd_value = event_flags;
            uef_pkg::UEF_REG_INTEN: rd_value = int_enable;
            uef_pkg::UEF_REG_ERRF: rd_value = err_flags;
            uef_pkg::UEF_REG_ERREN: rd_value = err_enable;
            uef_pkg::UEF_REG_XSTAT: rd_value = xstat_head;
            uef_pkg::UEF_REG_CTRL: rd_value = {7'h00, host_en};
            default: rd_value = 8'h00;
        endcase
    end

    // read data captured at the address phase edge; a read right behind a write sees the old value
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            HRDATA <= 32'h00000000;
        else if (addr_phase && !HWRITE)
            HRDATA <= {24'h000000, rd_value};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            int_enable <= `UEF_REG_RESET;
        else if (wr_pend && wr_sel == uef_pkg::UEF_REG_INTEN)
            int_enable <= HWDATA[7:0];
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            err_enable <= `UEF_REG_RESET;
        else if (wr_pend && wr_sel == uef_pkg::UEF_REG_ERREN)
            err_enable <= HWDATA[7:0];
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            host_en <= 1'b0;
        else if (wr_pend && wr_sel == uef_pkg::UEF_REG_CTRL)
            host_en <= HWDATA[`UEF_BIT_HOST_ROLE_ENABLE];
    end

    assign HOST_ROLE_ENABLE = host_en;

    ////////////////////////////////////////////////////////////////////////////////
    // individual error flags, write one to clear, new error wins over clear
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            err_flags <= `UEF_FLAGS_RESET;
        else if (wr_pend && wr_sel == uef_pkg::UEF_REG_ERRF)
            err_flags <= (err_flags & ~HWDATA[7:0]) | ERROR_EVENTS;
        else
            err_flags <= err_flags | ERROR_EVENTS;
    end

    assign error_summary_flag = |(err_flags & err_enable);

    ////////////////////////////////////////////////////////////////////////////////
    // line-state timers
    always_ff @(posedge REF_CLK)
    begin
        if (RESET || !BUS_K_STATE)
            k_cnt <= '0;
        else if (k_cnt != `UEF_K_W'(`UEF_K_CYCLES))
            k_cnt <= `UEF_K_W'(k_cnt + 1'b1);
    end

    assign resume_hit = BUS_K_STATE && k_cnt == `UEF_K_W'(`UEF_K_CYCLES - 1);

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || !BUS_IDLE)
            idle_cnt <= '0;
        else if (idle_cnt != `UEF_IDLE_W'(IDLE_CYCLES))
            idle_cnt <= `UEF_IDLE_W'(idle_cnt + 1'b1);
    end

    // only a continuous idle counts; one cycle with BUS_IDLE low restarts the wait
    assign idle_hit = BUS_IDLE && idle_cnt == `UEF_IDLE_W'(IDLE_CYCLES - 1);

    always_ff @(posedge REF_CLK)
    begin
        if (RESET || BUS_ACTIVE)
            q_cnt <= '0;
        else if (q_cnt != `UEF_K_W'(`UEF_K_CYCLES))
            q_cnt <= `UEF_K_W'(q_cnt + 1'b1);
    end

    assign quiet_ok = q_cnt == `UEF_K_W'(`UEF_K_CYCLES);

    ////////////////////////////////////////////////////////////////////////////////
    // transfer status queue
    assign token_push = TOKEN_DONE && TOKEN_READY;
    assign TOKEN_READY = !fifo_full;
    assign token_pop = flag_clr[`UEF_BIT_TOKEN] && hs_flags[`UEF_BIT_TOKEN];

    uef_stat_fifo #(.WIDTH(`UEF_XSTAT_W), .DEPTH(`UEF_XSTAT_DEPTH)) u_xstat
    (
        .clk(REF_CLK),
        .reset(RESET),
        .push(token_push),
        .push_data(TOKEN_STATUS),
        .full(fifo_full),
        .pop(token_pop),
        .head(xstat_head),
        .count(fifo_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // event flags: set wins over a same-cycle clear
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[`UEF_BIT_STALL] = host_en ? STALL_RX : STALL_TX;
        flag_set[`UEF_BIT_ATTACH] = ATTACH_SEEN && host_en && quiet_ok && !BUS_SE0;
        flag_set[`UEF_BIT_RESUME] = resume_hit;
        flag_set[`UEF_BIT_IDLE] = idle_hit;
        flag_set[`UEF_BIT_TOKEN] = token_push || (token_pop && fifo_count > 1);
        flag_set[`UEF_BIT_SOF] = host_en ? SOF_THRESHOLD : SOF_RECEIVED;
        flag_set[`UEF_BIT_RST] = host_en ? DETACH_SEEN : USB_RESET_SEEN;
    end

    assign flag_clr = (wr_pend && (wr_sel == uef_pkg::UEF_REG_FLAGS || wr_sel == uef_pkg::UEF_REG_CLEAR))
        ? (HWDATA[7:0] & `UEF_HS_MASK) : 8'h00;
    assign next_hs_flags = ((hs_flags & ~flag_clr) | flag_set) & `UEF_HS_MASK;

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            hs_flags <= `UEF_FLAGS_RESET;
        else
            hs_flags <= next_hs_flags;
    end

    always_comb
    begin
        event_flags = hs_flags;
        event_flags[`UEF_BIT_ERR] = error_summary_flag;
    end

    // resume enable is left to software; it should stay off outside suspend
    assign IRQ = |(event_flags & int_enable);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_upper_zero;
        @(posedge REF_CLK) disable iff (RESET) addr_phase && !HWRITE |=> HRDATA[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

    property p_w1c;
        @(posedge REF_CLK) disable iff (RESET)
        wr_pend && wr_sel == uef_pkg::UEF_REG_FLAGS && HWDATA[7] && !flag_set[7] |=> !hs_flags[7];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear stall flag");

    property p_err_enabled;
        @(posedge REF_CLK) disable iff (RESET)
        ((ERROR_EVENTS & err_enable) != 8'h00) && !(wr_pend && wr_sel == uef_pkg::UEF_REG_ERREN)
        |=> event_flags[1];
    endproperty
    a_err_enabled: assert property (p_err_enabled) else $error("enabled error missed summary");

    property p_stall_dev;
        @(posedge REF_CLK) disable iff (RESET) !host_en && STALL_TX |=> hs_flags[7];
    endproperty
    a_stall_dev: assert property (p_stall_dev) else $error("sent stall not flagged");

    property p_attach_qual;
        @(posedge REF_CLK) disable iff (RESET)
        $rose(hs_flags[6]) |-> $past(host_en) && !$past(BUS_SE0) && $past(q_cnt) == 7'h64;
    endproperty
    a_attach_qual: assert property (p_attach_qual) else $error("attach flag without qualifier");

    property p_resume_time;
        @(posedge REF_CLK) disable iff (RESET) $rose(hs_flags[5]) |-> $past(k_cnt) == 7'h63;
    endproperty
    a_resume_time: assert property (p_resume_time) else $error("resume flag at wrong k duration");

    property p_idle_time;
        @(posedge REF_CLK) disable iff (RESET)
        $rose(hs_flags[4]) |-> $past(idle_cnt) == `UEF_IDLE_W'(IDLE_CYCLES - 1);
    endproperty
    a_idle_time: assert property (p_idle_time) else $error("idle flag at wrong idle duration");

    property p_token_set;
        @(posedge REF_CLK) disable iff (RESET) token_push |=> hs_flags[3] && fifo_count != 3'h0;
    endproperty
    a_token_set: assert property (p_token_set) else $error("token done not flagged");

    property p_fifo_adv;
        @(posedge REF_CLK) disable iff (RESET)
        token_pop && !token_push && fifo_count > 3'h1 |=> hs_flags[3] && fifo_count == $past(fifo_count) - 3'h1;
    endproperty
    a_fifo_adv: assert property (p_fifo_adv) else $error("status queue did not advance");

    property p_sof_host;
        @(posedge REF_CLK) disable iff (RESET) host_en && SOF_THRESHOLD |=> hs_flags[2];
    endproperty
    a_sof_host: assert property (p_sof_host) else $error("sof threshold not flagged");

    property p_rst_dev;
        @(posedge REF_CLK) disable iff (RESET) !host_en && USB_RESET_SEEN |=> hs_flags[0];
    endproperty
    a_rst_dev: assert property (p_rst_dev) else $error("bus reset not flagged");

    property p_detach_host;
        @(posedge REF_CLK) disable iff (RESET) host_en && DETACH_SEEN |=> hs_flags[0];
    endproperty
    a_detach_host: assert property (p_detach_host) else $error("detach not flagged");

    property p_irq_gate;
        @(posedge REF_CLK) disable iff (RESET)
        !int_enable[1] && ((hs_flags & int_enable) == 8'h00) |-> !IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("error reached irq while disabled");

    property p_zero_write;
        @(posedge REF_CLK) disable iff (RESET)
        wr_pend && wr_sel == uef_pkg::UEF_REG_FLAGS && (HWDATA[7:0] & 8'hfd) == 8'h00 && flag_set == 8'h00
        |=> hs_flags == $past(hs_flags);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed a flag");
endmodule : uef_top

//--- test/tb_usb_event_flag_register.sv
// self-checking bench of the usb event flag block
`timescale 1ns/100ps
`include "uef_cfg.svh"
module tb_usb_event_flag_register;
    localparam int IDLE_N = 200;
    localparam logic [31:0] A_FLG = {24'h0, `UEF_OFS_FLAGS};
    localparam logic [31:0] A_CLR = {24'h0, `UEF_OFS_CLEAR};
    localparam logic [31:0] A_IEN = {24'h0, `UEF_OFS_INTEN};
    localparam logic [31:0] A_ERF = {24'h0, `UEF_OFS_ERRF};
    localparam logic [31:0] A_EEN = {24'h0, `UEF_OFS_ERREN};
    localparam logic [31:0] A_XST = {24'h0, `UEF_OFS_XSTAT};
    localparam logic [31:0] A_CTL = {24'h0, `UEF_OFS_CTRL};
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic [6:0] ev;
    logic tok_done;
    logic [7:0] tok_stat;
    logic [7:0] err_ev;
    logic k_st;
    logic idl;
    logic act;
    logic se0;
    logic TOKEN_READY;
    logic HOST_ROLE_ENABLE;
    logic IRQ;
    logic [31:0] rd;
    int mismatches = 0;
    int checks_done = 0;
    int i;

    always #12.5 REF_CLK = ~REF_CLK;

    uef_top #(.IDLE_CYCLES(IDLE_N)) dut
    (
        .REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STALL_RX(ev[6]), .STALL_TX(ev[5]), .ATTACH_SEEN(ev[4]),
        .DETACH_SEEN(ev[3]), .USB_RESET_SEEN(ev[2]), .SOF_RECEIVED(ev[1]), .SOF_THRESHOLD(ev[0]),
        .TOKEN_DONE(tok_done), .TOKEN_STATUS(tok_stat), .TOKEN_READY(TOKEN_READY), .ERROR_EVENTS(err_ev),
        .BUS_K_STATE(k_st), .BUS_IDLE(idl), .BUS_ACTIVE(act), .BUS_SE0(se0),
        .HOST_ROLE_ENABLE(HOST_ROLE_ENABLE), .IRQ(IRQ)
    );

    uef_usb_partner partner
    (
        .clk(REF_CLK), .ev(ev), .token_done(tok_done), .token_status(tok_stat), .err_ev(err_ev),
        .k_state(k_st), .idle(idl), .active(act), .se0(se0)
    );

    ////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wait_ready;
        int n;
        n = 0;
        @(posedge REF_CLK);
        while (HREADYOUT !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                mismatches++;
                close_out();
            end
            @(posedge REF_CLK);
        end
    endtask : wait_ready

    // one single ahb-lite transfer, read data taken at the edge closing the data phase
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        wait_ready();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        rd = HRDATA;
    endtask : bus

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdc

    // pins sampled mid-cycle so the edge's updates have landed
    task pins(input logic [2:0] exp);
        @(negedge REF_CLK);
        chk("ready role irq", {29'h0, exp}, {29'h0, TOKEN_READY, HOST_ROLE_ENABLE, IRQ});
        @(posedge REF_CLK);
    endtask : pins

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        for (i = 0; i < 7; i++)
            rdc("reset value", 32'(4 * i), 32'h0);
        chk("resp", 32'h0, {31'h0, HRESP});
        // device role: host-only events must not set anything
        partner.pulse(7'h59, 8'h00);
        rdc("device ignores host events", A_FLG, 32'h0);
        partner.pulse(7'h26, 8'h00);
        rdc("device events", A_FLG, 32'h85);
        wr(A_FLG, 32'h0);
        rdc("zero write", A_FLG, 32'h85);
        wr(A_FLG, 32'hffffff04);
        rdc("upper bits and clear", A_FLG, 32'h81);
        wr(A_FLG, 32'h81);
        rdc("all cleared", A_FLG, 32'h0);
        // host role
        wr(A_CTL, 32'h1);
        pins(3'b110);
        partner.pulse(7'h26, 8'h00);
        rdc("host ignores device events", A_FLG, 32'h0);
        partner.pulse(7'h49, 8'h00);
        rdc("host events", A_FLG, 32'h85);
        wr(A_FLG, 32'h85);
        // attach needs quiet bus and no se0
        partner.pulse(7'h10, 8'h00);
        rdc("attach while active", A_FLG, 32'h0);
        partner.line(1'b0, 1'b1);
        repeat (110) @(posedge REF_CLK);
        partner.pulse(7'h10, 8'h00);
        rdc("attach in se0", A_FLG, 32'h0);
        partner.line(1'b0, 1'b0);
        partner.pulse(7'h10, 8'h00);
        rdc("attach", A_FLG, 32'h40);
        wr(A_FLG, 32'h40);
        // resume after 2.5 us of k-state, idle after the idle count
        partner.hold(90, 1'b0);
        rdc("short k-state", A_FLG, 32'h0);
        partner.hold(102, 1'b0);
        rdc("resume", A_FLG, 32'h20);
        wr(A_CLR, 32'h20);
        partner.hold(IDLE_N - 10, 1'b1);
        rdc("short idle", A_FLG, 32'h0);
        partner.hold(IDLE_N + 2, 1'b1);
        rdc("idle", A_FLG, 32'h10);
        wr(A_FLG, 32'h10);
        // errors reach the summary only when enabled
        wr(A_EEN, 32'h1);
        partner.pulse(7'h00, 8'h02);
        rdc("masked error", A_FLG, 32'h0);
        partner.pulse(7'h00, 8'h01);
        rdc("enabled error", A_FLG, 32'h2);
        rdc("error flags", A_ERF, 32'h3);
        rdc("error enable", A_EEN, 32'h1);
        wr(A_FLG, 32'h2);
        rdc("summary read-only", A_FLG, 32'h2);
        pins(3'b110);
        wr(A_IEN, 32'h2);
        pins(3'b111);
        wr(A_ERF, 32'hff);
        rdc("summary follows", A_FLG, 32'h0);
        pins(3'b110);
        // raise, mask and clear; resume enable kept off outside suspend
        wr(A_IEN, 32'h80);
        partner.pulse(7'h40, 8'h00);
        pins(3'b111);
        wr(A_IEN, 32'h0);
        pins(3'b110);
        wr(A_IEN, 32'h80);
        pins(3'b111);
        wr(A_FLG, 32'h80);
        pins(3'b110);
        // five tokens into a four-deep queue: the last is dropped
        for (i = 0; i < 5; i++)
            partner.token(8'(8'h11 * (i + 1)));
        pins(3'b010);
        rdc("token flag", A_FLG, 32'h8);
        for (i = 0; i < 4; i++)
        begin
            rdc("token status", A_XST, 32'(8'h11 * (i + 1)));
            wr(A_FLG, 32'h8);
        end
        rdc("queue drained", A_FLG, 32'h0);
        pins(3'b110);
        rdc("unmapped", 32'h20, 32'h0);
        rdc("high address", 32'h100, 32'h0);
        // reset in mid-run clears flags and role
        partner.pulse(7'h40, 8'h00);
        RESET <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        rdc("flags after reset", A_FLG, 32'h0);
        pins(3'b100);
        close_out();
    end
endmodule : tb_usb_event_flag_register

//--- test/uef_usb_partner.sv
// far-side usb model: event pulses from the serial engine and bus line levels
`timescale 1ns/100ps
module uef_usb_partner
(
    // clock
    input wire logic clk,
    // events: stall_rx, stall_tx, attach, detach, usb_reset, sof_rx, sof_thr
    output logic [6:0] ev,
    output logic token_done,
    output logic [7:0] token_status,
    output logic [7:0] err_ev,
    // line state
    output logic k_state,
    output logic idle,
    output logic active,
    output logic se0
);
    initial
    begin
        ev = 7'h00;
        token_done = 1'b0;
        token_status = 8'h00;
        err_ev = 8'h00;
        k_state = 1'b0;
        idle = 1'b0;
        active = 1'b1;
        se0 = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task pulse(input logic [6:0] m, input logic [7:0] e);
        @(posedge clk);
        ev <= m;
        err_ev <= e;
        @(posedge clk);
        ev <= 7'h00;
        err_ev <= 8'h00;
    endtask : pulse

    // status is not held after the strobe: show the inverse
    task token(input logic [7:0] s);
        @(posedge clk);
        token_done <= 1'b1;
        token_status <= s;
        @(posedge clk);
        token_done <= 1'b0;
        token_status <= ~s;
    endtask : token

    // one continuous run of k-state (which 0) or idle (which 1)
    task hold(input int n, input bit which);
        @(posedge clk);
        if (which)
            idle <= 1'b1;
        else
            k_state <= 1'b1;
        repeat (n) @(posedge clk);
        idle <= 1'b0;
        k_state <= 1'b0;
    endtask : hold

    task line(input logic a, input logic s);
        @(posedge clk);
        active <= a;
        se0 <= s;
    endtask : line
endmodule : uef_usb_partner
